/* rtl/hcse_evaluator.v */
// Receiver-side learn and synchronisation-window evaluator
`default_nettype none
`include "hcse_regs.vh"
module hcse_evaluator #(
  parameter CNT_W   = `HCSE_CNT_W,
  parameter ENTRIES = `HCSE_ENTRIES,
  parameter SINGLE  = `HCSE_SINGLE_WIN,
  parameter DOUBLE  = `HCSE_DOUBLE_WIN,
  parameter ADV_ON_DOUBT = 1
) (
  // Clock and reset
  input  wire                   core_clk,
  input  wire                   rst,
  // Received code word, one-cycle strobe
  input  wire                   rx_valid,
  input  wire [`HCSE_SER_W-1:0] rx_serial,
  input  wire [`HCSE_HOP_W-1:0] rx_hop,
  input  wire [3:0]             rx_buttons,
  // Learn control
  input  wire                   learn_mode,
  // Cipher core interface
  output reg  [`HCSE_HOP_W-1:0] dec_data_q,
  output reg  [`HCSE_KEY_W-1:0] dec_key_q,
  output wire                   dec_req,
  input  wire [`HCSE_HOP_W-1:0] dec_plain,
  // Key generation result (from serial)
  input  wire [`HCSE_KEY_W-1:0] gen_key,
  // Results
  output reg                    exec_q,
  output reg  [3:0]             exec_buttons_q,
  output reg                    learned_q,
  output reg                    learn_fail_q,
  output reg                    busy_q
);
  // ****************************************************
  // Local types
  // ****************************************************
  localparam IDX_W = 3;
  localparam [6:0] S_IDLE = 7'b0000001, S_LOOK = 7'b0000010,
                   S_DEC  = 7'b0000100, S_WAIT = 7'b0001000,
                   S_EVAL = 7'b0010000, S_LRN  = 7'b0100000,
                   S_DONE = 7'b1000000;
  // Unsigned modulo difference of counters
  function [CNT_W-1:0] cdiff;
    input [CNT_W-1:0] a;
    input [CNT_W-1:0] b;
    begin
      cdiff = a - b;
    end
  endfunction
  // ****************************************************
  // Learned transmitter table
  // ****************************************************
  reg [`HCSE_SER_W-1:0] tbl_ser [0:ENTRIES-1];
  reg [CNT_W-1:0]       tbl_cnt [0:ENTRIES-1];
  reg [`HCSE_KEY_W-1:0] tbl_key [0:ENTRIES-1];
  reg [ENTRIES-1:0]     tbl_vld_q;             // Entry in use
  reg [IDX_W-1:0]       next_q;                // Next slot for learning
  // Capture registers
  reg [6:0]             st_q;
  reg [`HCSE_SER_W-1:0] ser_q;
  reg [3:0]             btn_q;
  reg [IDX_W-1:0]       hit_q;
  reg                   lrn_q;                 // Learn pass
  reg                   lrn_first_q;           // First learn press held
  reg [CNT_W-1:0]       lrn_cnt_q;             // Buffered learn counter
  reg                   dbl_pend_q;            // Double window pending
  reg [CNT_W-1:0]       dbl_cnt_q;
  reg [IDX_W-1:0]       dbl_idx_q;
  reg [`HCSE_HOP_W-1:0] plain_q;
  reg                   req_q;
  wire                  dec_done;
  integer               i;
  // ****************************************************
  // Serial lookup (combinational)
  // ****************************************************
  reg             hit;
  reg [IDX_W-1:0] hit_idx;
  always @* begin
    hit     = 1'b0;
    hit_idx = {IDX_W{1'b0}};
    for (i = 0; i < ENTRIES; i = i + 1) begin
      if (tbl_vld_q[i] && tbl_ser[i] == ser_q && !hit) begin
        hit     = 1'b1;
        hit_idx = i[IDX_W-1:0];
      end
    end
  end
  // ****************************************************
  // Decrypted field checks
  // ****************************************************
  wire [CNT_W-1:0] rx_cnt = plain_q[CNT_W-1:0];
  // Discrimination: low serial bits and button status must match
  wire disc_ok = (plain_q[31:28] == btn_q) &&
                 (plain_q[27:16] == ser_q[11:0]) &&
                 (CNT_W == 16);
  wire [CNT_W-1:0] diff = cdiff(rx_cnt, tbl_cnt[hit_q]);
  wire single_ok = (diff != {CNT_W{1'b0}}) &&
                   ({16'h0000, diff} <= SINGLE);
  wire double_ok = ({16'h0000, diff} > SINGLE) &&
                   ({16'h0000, diff} <= DOUBLE);
  wire seq_dbl   = dbl_pend_q && (dbl_idx_q == hit_q) &&
                   (cdiff(rx_cnt, dbl_cnt_q) == 1);
  assign dec_req = req_q;
  // Cipher latency model port
  hcse_cipher_port #(.LAT(`HCSE_CIPH_LAT)) u_ciph (
    .core_clk (core_clk),
    .rst      (rst),
    .req      (req_q),
    .done     (dec_done)
  );
  // ****************************************************
  // Control state machine
  // ****************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE;
      ser_q <= 32'h0000_0000;
      btn_q <= 4'h0;
      hit_q <= {IDX_W{1'b0}};
      lrn_q <= 1'b0;
      lrn_first_q <= 1'b0;
      lrn_cnt_q <= {CNT_W{1'b0}};
      dbl_pend_q <= 1'b0;
      dbl_cnt_q <= {CNT_W{1'b0}};
      dbl_idx_q <= {IDX_W{1'b0}};
      plain_q <= 32'h0000_0000;
      req_q <= 1'b0;
      dec_data_q <= 32'h0000_0000;
      dec_key_q <= 64'h0000_0000_0000_0000;
      tbl_vld_q <= {ENTRIES{1'b0}};
      next_q <= {IDX_W{1'b0}};
      exec_q <= 1'b0;
      exec_buttons_q <= 4'h0;
      learned_q <= 1'b0;
      learn_fail_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      req_q <= 1'b0;
      exec_q <= 1'b0;
      learned_q <= 1'b0;
      learn_fail_q <= 1'b0;
      case (st_q)
        // Wait for a code word
        S_IDLE: begin
          busy_q <= 1'b0;
          if (rx_valid) begin
            ser_q <= rx_serial;
            btn_q <= rx_buttons;
            dec_data_q <= rx_hop;
            lrn_q <= learn_mode;
            busy_q <= 1'b1;
            st_q <= S_LOOK;
          end
        end
        // Table lookup or key derivation
        S_LOOK: begin
          if (lrn_q) begin
            dec_key_q <= gen_key;
            req_q <= 1'b1;
            st_q <= S_WAIT;
          end else if (hit) begin
            hit_q <= hit_idx;
            dec_key_q <= tbl_key[hit_idx];
            req_q <= 1'b1;
            st_q <= S_WAIT;
          end else begin
            busy_q <= 1'b0; // Unknown serial drops out at once
            st_q <= S_IDLE;
          end
        end
        // Wait for decryption answer
        S_WAIT: begin
          if (dec_done)
            st_q <= S_DEC;
        end
        // Capture plain text
        S_DEC: begin
          plain_q <= dec_plain;
          st_q <= lrn_q ? S_LRN : S_EVAL;
        end
        // Synchronisation window evaluation
        S_EVAL: begin
          st_q <= S_DONE;
          if (disc_ok) begin
            if (single_ok || seq_dbl) begin
              exec_q <= 1'b1;
              exec_buttons_q <= btn_q;
              tbl_cnt[hit_q] <= rx_cnt;
              dbl_pend_q <= 1'b0;
            end else if (double_ok) begin
              dbl_pend_q <= 1'b1;
              dbl_cnt_q <= rx_cnt;
              dbl_idx_q <= hit_q;
              // Advance to the doubtful counter so its replay is blocked
              if (ADV_ON_DOUBT != 0)
                tbl_cnt[hit_q] <= rx_cnt;
            end
            // Blocked window: ignored
          end
        end
        // Learning two-press sequence
        S_LRN: begin
          st_q <= S_DONE;
          if (!disc_ok) begin
            learn_fail_q <= 1'b1;
            lrn_first_q <= 1'b0;
          end else if (!lrn_first_q) begin
            lrn_first_q <= 1'b1;
            lrn_cnt_q <= rx_cnt;
          end else if (cdiff(rx_cnt, lrn_cnt_q) == 1) begin
            tbl_ser[next_q] <= ser_q;
            tbl_cnt[next_q] <= rx_cnt;
            tbl_key[next_q] <= dec_key_q;
            tbl_vld_q[next_q] <= 1'b1;
            next_q <= next_q + 1'b1;
            lrn_first_q <= 1'b0;
            learned_q <= 1'b1;
          end else begin
            lrn_first_q <= 1'b0;
            learn_fail_q <= 1'b1;
          end
        end
        default: begin
          busy_q <= 1'b0;
          st_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* rtl/hcse_regs.vh */
// Constants for the hopping code synchronisation evaluator
`ifndef HCSE_REGS_VH
`define HCSE_REGS_VH
`define HCSE_SER_W      32
`define HCSE_KEY_W      64
`define HCSE_HOP_W      32
`define HCSE_CNT_W      16
`define HCSE_DISC_W     16
`define HCSE_SINGLE_WIN 16
`define HCSE_DOUBLE_WIN 32768
`define HCSE_ENTRIES    8
`define HCSE_CIPH_LAT   4
`endif

/* rtl/hcse_cipher_port.v */
// Cipher request/answer stub port: fixed-latency handshake to external core
`default_nettype none
`include "hcse_regs.vh"
module hcse_cipher_port #(
  parameter LAT = `HCSE_CIPH_LAT
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // Request from evaluator
  input  wire        req,
  // Answer back
  output wire        done
);
  // ****************************************************
  // Latency counter for the external cipher core
  // ****************************************************
  reg [7:0] cnt_q;     // Cycles remaining
  reg       busy_q;    // Request in flight
  // Count down while busy
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= 8'h00;
      busy_q <= 1'b0;
    end else if (req && !busy_q) begin
      cnt_q  <= LAT[7:0];
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (cnt_q == 8'h01)
        busy_q <= 1'b0;
      cnt_q <= cnt_q - 8'h01;
    end
  end
  assign done = busy_q && (cnt_q == 8'h01);
endmodule
`default_nettype wire

/* test/hcse_eval_monitor.sv */
// Port assertions for the hopping code evaluator
`default_nettype none
module hcse_eval_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Request side
  input wire logic rx_valid,
  input wire logic busy_q,
  input wire logic dec_req,
  // Results
  input wire logic exec_q,
  input wire logic learned_q,
  input wire logic learn_fail_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking mon_cb @(posedge core_clk); endclocking
  default disable iff (rst);
  exec_pulse_a: assert property (exec_q |=> !exec_q)
    else $error("exec pulse longer than one cycle");
  learn_pulse_a: assert property (learned_q |=> !learned_q)
    else $error("learned pulse longer than one cycle");
  fail_pulse_a: assert property ($rose(learn_fail_q) |=> !learn_fail_q)
    else $error("learn fail pulse longer than one cycle");
  req_pulse_a: assert property (dec_req |=> !dec_req)
    else $error("cipher request longer than one cycle");
  take_busy_a: assert property (rx_valid && !busy_q |=> busy_q)
    else $error("word taken without going busy");
  req_busy_a: assert property (dec_req |-> busy_q)
    else $error("cipher request while idle");
  exec_in_job_a: assert property (exec_q |-> $past(busy_q))
    else $error("exec without an evaluation in flight");
  one_result_a: assert property ($onehot0({exec_q, learned_q, learn_fail_q}))
    else $error("two results in one cycle");
endmodule
bind hcse_evaluator hcse_eval_monitor hcse_eval_monitor_inst (
  .core_clk(core_clk), .rst(rst), .rx_valid(rx_valid), .busy_q(busy_q),
  .dec_req(dec_req), .exec_q(exec_q), .learned_q(learned_q),
  .learn_fail_q(learn_fail_q));
`default_nettype wire

/* test/hcse_tx_model.sv */
// Transmitter and cipher stand-in facing the evaluator
`default_nettype none
module hcse_tx_model (
  // Word to send
  input  wire logic [31:0] serial,
  input  wire logic [15:0] cnt,
  input  wire logic [3:0]  btn,
  output logic      [31:0] hop,
  // Cipher and key generation side
  input  wire logic [31:0] dec_data_q,
  input  wire logic [63:0] dec_key_q,
  output logic      [31:0] dec_plain,
  output logic      [63:0] gen_key
);
  timeunit 1ns;
  timeprecision 1ns;
  // Key per serial; only hopping words are sent, never a seed
  assign gen_key = {~serial, serial ^ 32'h5A5A_A5A5};
  // Counter only inside the encrypted part, serial sent plain
  assign hop = {btn, serial[11:0], cnt} ^ gen_key[31:0];
  // Same symmetric cipher in both directions
  assign dec_plain = dec_data_q ^ dec_key_q[31:0];
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the hopping code evaluator
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, rst, rx_valid, learn_mode, corrupt;
  logic [31:0] rx_serial, hop, dec_data_q, dec_plain;
  logic [15:0] cnt, ref_c, nc, d;
  logic [3:0]  rx_buttons, b, exec_buttons_q;
  logic [63:0] dec_key_q, gen_key;
  logic        dec_req, exec_q, learned_q, learn_fail_q, busy_q;
  logic [7:0]  seen;
  int          err_count, n_checks, k;
  logic [15:0] offs [3] = '{16'h0000, 16'hFFFB, 16'h8001};
  wire  [31:0] rx_hop = corrupt ? hop ^ 32'h0010_0000 : hop;
  localparam logic [31:0] S = 32'h1234_5678;
  hcse_evaluator hcse_evaluator_inst (.core_clk(core_clk), .rst(rst),
    .rx_valid(rx_valid), .rx_serial(rx_serial), .rx_hop(rx_hop),
    .rx_buttons(rx_buttons), .learn_mode(learn_mode),
    .dec_data_q(dec_data_q), .dec_key_q(dec_key_q), .dec_req(dec_req),
    .dec_plain(dec_plain), .gen_key(gen_key), .exec_q(exec_q),
    .exec_buttons_q(exec_buttons_q), .learned_q(learned_q),
    .learn_fail_q(learn_fail_q), .busy_q(busy_q));
  hcse_tx_model hcse_tx_model_inst (.serial(rx_serial), .cnt(cnt),
    .btn(rx_buttons), .hop(hop), .dec_data_q(dec_data_q),
    .dec_key_q(dec_key_q), .dec_plain(dec_plain), .gen_key(gen_key));
  // Expected result byte
  function automatic logic [7:0] expv(input logic ex, lr, lf,
                                      input logic [3:0] bt);
    expv = {bt & {4{ex}}, 1'b0, lf, lr, ex};
  endfunction
  // Window of a modulo-16-bit distance: 0 blocked, 1 single, 2 double
  function automatic logic [1:0] win(input logic [15:0] dd);
    win = (dd == 0) ? 2'd0 : (dd <= 16'h0010) ? 2'd1 :
          (dd <= 16'h8000) ? 2'd2 : 2'd0;
  endfunction
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // Send one word and gather the result pulses
  task automatic word(input logic [31:0] s, input logic [15:0] c,
                      input logic [3:0] bt, input logic lm, bad);
    int i;
    @(negedge core_clk);
    rx_serial = s; cnt = c; rx_buttons = bt; learn_mode = lm;
    corrupt = bad; rx_valid = 1'b1;
    @(negedge core_clk);
    rx_valid = 1'b0;
    seen = 8'h00;
    for (i = 0; i < 40; i++) begin
      @(posedge core_clk); #1;
      if (exec_q === 1'b1) seen = seen | {exec_buttons_q, 4'h1};
      if (learned_q === 1'b1) seen[1] = 1'b1;
      if (learn_fail_q === 1'b1) seen[2] = 1'b1;
      if (i > 10 && busy_q === 1'b0) break;
    end
    if (busy_q !== 1'b0) begin
      err_count++;
      test_done();
    end
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    rst = 1'b1; rx_valid = 1'b0; learn_mode = 1'b0; corrupt = 1'b0;
    rx_serial = S; cnt = 16'h0000; rx_buttons = 4'h0;
    err_count = 0; n_checks = 0;
    void'($urandom(26086));
    repeat (3) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    chk("reset", 8'h00, {exec_q, learned_q, learn_fail_q, busy_q, 4'h0});
    word(S, 16'h0005, 4'h1, 1'b0, 1'b0);
    chk("unknown", 8'h00, seen);
    word(S, 16'hFFE0, 4'h1, 1'b1, 1'b0);
    chk("learn1", 8'h00, seen);
    word(S, 16'hFFE1, 4'h1, 1'b1, 1'b0);
    chk("learn2", expv(0, 1, 0, 0), seen);
    ref_c = 16'hFFE1;
    word(S, ref_c + 16'h0001, 4'h2, 1'b0, 1'b1);
    chk("corrupt", 8'h00, seen);
    for (k = 0; k < 6; k++) begin
      nc = ref_c + (k < 2 ? 16'h0010 : 16'(1 + $urandom % 16));
      b = 4'(1 + $urandom % 15);
      word(S, nc, b, 1'b0, 1'b0);
      chk("single", expv(win(nc - ref_c) == 2'd1, 0, 0, b), seen);
      ref_c = nc;
    end
    for (k = 0; k < 2; k++) begin
      d = k ? 16'h8000 : 16'h0011;
      word(S, ref_c + d, 4'h4, 1'b0, 1'b0);
      chk("double1", 8'h00, seen);
      word(S, ref_c + d, 4'h4, 1'b0, 1'b0);
      chk("replay", 8'h00, seen);
      word(S, ref_c + d + 16'h0001, 4'h4, 1'b0, 1'b0);
      chk("double2", expv(1, 0, 0, 4'h4), seen);
      ref_c = ref_c + d + 16'h0001;
    end
    for (k = 0; k < 3; k++) begin
      word(S, ref_c + offs[k], 4'h8, 1'b0, 1'b0);
      chk("blocked", 8'h00, seen);
    end
    word(32'h0BAD_0C0D, 16'h0100, 4'h1, 1'b1, 1'b0);
    word(32'h0BAD_0C0D, 16'h0102, 4'h1, 1'b1, 1'b0);
    chk("learn_gap", expv(0, 0, 1, 0), seen);
    word(32'h0BAD_0C0D, 16'h0103, 4'h1, 1'b0, 1'b0);
    chk("not_learned", 8'h00, seen);
    word(32'h0BAD_0C0D, 16'h0200, 4'h1, 1'b1, 1'b1);
    chk("learn_bad", expv(0, 0, 1, 0), seen);
    test_done();
  end
endmodule
`default_nettype wire
